// File: rtl/par_regs.svh
// Constants for the PCI arbitration pin role selector.
// Assumes inclusion by rtl files only; definitions only.
`ifndef PAR_REGS_SVH
`define PAR_REGS_SVH
// Cycles after reset release for which grant line 1 is undefined
`define PAR_GNT1_UNDEF_CYCLES 2'h1
// Index of each pin within the request and grant groups
`define PAR_IDX_REQ_IDSEL 2
`define PAR_IDX_REQ_OWN 0
`define PAR_IDX_GNT_INTA 2
`define PAR_IDX_GNT_EPROM 1
`define PAR_IDX_GNT_OWN 0
`endif

// File: rtl/par_pkg.sv
// Types for the PCI arbitration pin role selector.
// Assumes nothing beyond a SystemVerilog compiler.
package par_pkg;
    // Role latched at cold reset
    typedef enum logic [1:0] {
        PAR_ROLE_HOST = 2'b00,
        PAR_ROLE_SAT = 2'b01,
        PAR_ROLE_SAT_BOOT = 2'b10
    } par_role_e;
    // One two-signal two-way pin as seen by the core
    typedef struct packed {
        logic o;
        logic oe;
    } par_pad_s;
endpackage : par_pkg

// File: rtl/par_pad.sv
// One two-way pin: registered output value and output enable.
// Assumes the pad ring resolves the wire from o and oe.
`timescale 1ns/1ps
module par_pad
    import par_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic next_o,
    input wire logic next_oe,
    output par_pad_s pad
);
    par_pad_s next_pad;

    // Pack the next values
    always_comb begin
        next_pad.o = next_o;
        next_pad.oe = next_oe;
    end

    // Reset released: pin floats until the role decides
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pad <= '{o: 1'b1, oe: 1'b0};
        end else begin
            pad <= next_pad;
        end
    end
endmodule : par_pad

// File: rtl/par_pin_roles.sv
// PCI request, grant and lock pin role selector, host or satellite.
// Assumes synchronous inputs on the PCI clock and pads resolved outside.
//
// Contract
// - In host mode request line 2 is an input forwarded to the on-chip arbiter.
// - In satellite mode request line 2 is the configuration select input from the host.
// - Request line 0 is an arbiter input in host mode and the own request output in satellite mode.
// - In host mode grant line 2 is driven as the low-active grant for request line 2.
// - In satellite mode grant line 2 is the open-drain interrupt A output, only pulled low.
// - In host mode grant line 1 never grants and acts only as programmable I/O bit 7.
// - In satellite boot mode grant line 1 floats for one clock after reset, then is the serial memory chip select output.
// - Grant line 1 floats for one clock after reset in boot mode only; it is high in host unless PIO bit 7 drives it, low in satellite, chip select in boot.
// - Grant line 0 is an arbiter grant output in host mode and the own grant input in satellite mode.
`timescale 1ns/1ps
`include "par_regs.svh"
module par_pin_roles
    import par_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic strap_satellite,
    input wire logic strap_pci_boot,
    input wire logic [2:0] req_n_in,
    output par_pad_s req0_pad,
    input wire logic [2:0] gnt_n_in,
    output par_pad_s gnt2_pad,
    output par_pad_s gnt1_pad,
    output par_pad_s gnt0_pad,
    input wire logic lock_n,
    input wire logic arb_gnt2,
    input wire logic arb_gnt0,
    input wire logic pio7_out,
    input wire logic pio7_oe,
    input wire logic own_req,
    input wire logic inta,
    input wire logic eprom_cs,
    output logic [1:0] arb_req,
    output logic idsel,
    output logic own_gnt,
    output logic pio7_in,
    output logic lock,
    output par_role_e role
);
    logic strapped;
    logic next_strapped;
    par_role_e next_role;
    logic [1:0] settle_cnt;
    logic [1:0] next_settle_cnt;
    logic [1:0] next_arb_req;
    logic next_idsel;
    logic next_own_gnt;
    logic next_pio7_in;
    logic next_lock;
    logic [2:0] pad_o;
    logic [2:0] pad_oe;
    par_pad_s [2:0] pads;
    logic req0_o;

    // Strap capture on the first edge after release, then frozen
    always_comb begin
        next_strapped = 1'b1;
        next_role = role;
        if (!strapped) begin
            if (!strap_satellite) begin
                next_role = PAR_ROLE_HOST;
            end else if (strap_pci_boot) begin
                next_role = PAR_ROLE_SAT_BOOT;
            end else begin
                next_role = PAR_ROLE_SAT;
            end
        end
        next_settle_cnt = settle_cnt;
        if (settle_cnt != `PAR_GNT1_UNDEF_CYCLES) begin
            next_settle_cnt = settle_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strapped <= 1'b0;
            role <= PAR_ROLE_HOST;
            settle_cnt <= 2'h0;
        end else begin
            strapped <= next_strapped;
            role <= next_role;
            settle_cnt <= next_settle_cnt;
        end
    end

    // Inbound pin roles; unused inputs read inactive so the arbiter sees no phantom
    always_comb begin
        next_arb_req = 2'b00;
        next_idsel = 1'b0;
        next_own_gnt = 1'b0;
        next_pio7_in = 1'b0;
        next_lock = !lock_n;
        // Decode from the role being latched, so edge 1 shows no phantom request
        case (next_role)
            PAR_ROLE_HOST: begin
                next_arb_req[1] = !req_n_in[`PAR_IDX_REQ_IDSEL];
                next_arb_req[0] = !req_n_in[`PAR_IDX_REQ_OWN];
                next_pio7_in = gnt_n_in[`PAR_IDX_GNT_EPROM];
            end
            PAR_ROLE_SAT, PAR_ROLE_SAT_BOOT: begin
                next_idsel = req_n_in[`PAR_IDX_REQ_IDSEL];
                next_own_gnt = !gnt_n_in[`PAR_IDX_GNT_OWN];
            end
            default: begin
                next_arb_req = 2'b00;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arb_req <= 2'b00;
            idsel <= 1'b0;
            own_gnt <= 1'b0;
            pio7_in <= 1'b0;
            lock <= 1'b0;
        end else begin
            arb_req <= next_arb_req;
            idsel <= next_idsel;
            own_gnt <= next_own_gnt;
            pio7_in <= next_pio7_in;
            lock <= next_lock;
        end
    end

    // Outbound pin roles, decided one cycle ahead of the pad flops
    always_comb begin
        pad_o = 3'h7;
        pad_oe = 3'h0;
        case (next_role)
            PAR_ROLE_HOST: begin
                pad_o[`PAR_IDX_GNT_INTA] = !arb_gnt2;
                pad_oe[`PAR_IDX_GNT_INTA] = 1'b1;
                pad_o[`PAR_IDX_GNT_EPROM] = pio7_oe ? pio7_out : 1'b1;
                pad_oe[`PAR_IDX_GNT_EPROM] = 1'b1; // High until PIO takes it
                pad_o[`PAR_IDX_GNT_OWN] = !arb_gnt0;
                pad_oe[`PAR_IDX_GNT_OWN] = 1'b1;
            end
            PAR_ROLE_SAT, PAR_ROLE_SAT_BOOT: begin
                pad_o[`PAR_IDX_GNT_INTA] = 1'b0; // Open drain: only ever low
                pad_oe[`PAR_IDX_GNT_INTA] = inta;
                if (next_role == PAR_ROLE_SAT_BOOT) begin
                    pad_o[`PAR_IDX_GNT_EPROM] = eprom_cs;
                    pad_oe[`PAR_IDX_GNT_EPROM] = 1'b0; // Floats while settling
                    if (settle_cnt == `PAR_GNT1_UNDEF_CYCLES) begin
                        pad_oe[`PAR_IDX_GNT_EPROM] = 1'b1;
                    end
                end else begin
                    pad_o[`PAR_IDX_GNT_EPROM] = 1'b0;
                    pad_oe[`PAR_IDX_GNT_EPROM] = 1'b1;
                end
            end
            default: begin
                pad_oe = 3'h0;
            end
        endcase
        // Request 0 has its own value; sharing slot 0 would mask the host grant 0
        if (next_role == PAR_ROLE_HOST) begin
            req0_o = 1'b1;
        end else begin
            req0_o = !own_req;
        end
    end

    // Pad flops for the three grant lines
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_gnt_pad
            par_pad u_pad (
                .clk(clk),
                .rst_b(rst_b),
                .next_o(pad_o[gi]),
                .next_oe(pad_oe[gi]),
                .pad(pads[gi])
            );
        end
    endgenerate

    // Own request output only in satellite roles
    par_pad u_req0_pad (
        .clk(clk),
        .rst_b(rst_b),
        .next_o(req0_o),
        .next_oe(next_role != PAR_ROLE_HOST),
        .pad(req0_pad)
    );

    assign gnt2_pad = pads[2];
    assign gnt1_pad = pads[1];
    assign gnt0_pad = pads[0];

    // Role never changes once strapped
    property p_role_frozen;
        @(posedge clk) disable iff (!rst_b)
        $past(strapped) |-> $stable(role);
    endproperty
    a_role_frozen: assert property (p_role_frozen) else $error("role changed after strap");

    // Grant 1 high in host mode after settling
    property p_gnt1_host;
        @(posedge clk) disable iff (!rst_b)
        (strapped && role == PAR_ROLE_HOST && !pio7_oe) |=> (gnt1_pad.oe && gnt1_pad.o);
    endproperty
    a_gnt1_host: assert property (p_gnt1_host) else $error("grant 1 not high in host");

    // Grant 1 low in satellite non-boot
    property p_gnt1_sat;
        @(posedge clk) disable iff (!rst_b)
        (role == PAR_ROLE_SAT) |-> (gnt1_pad.oe && !gnt1_pad.o);
    endproperty
    a_gnt1_sat: assert property (p_gnt1_sat) else $error("grant 1 not low in satellite");

    // Interrupt pin never driven high
    property p_inta_od;
        @(posedge clk) disable iff (!rst_b)
        (strapped && role != PAR_ROLE_HOST && gnt2_pad.oe) |-> !gnt2_pad.o;
    endproperty
    a_inta_od: assert property (p_inta_od) else $error("interrupt pin driven high");

    // Host grant 2 follows arbiter one cycle later
    property p_host_gnt2;
        @(posedge clk) disable iff (!rst_b)
        (strapped && role == PAR_ROLE_HOST && arb_gnt2) |=> (gnt2_pad.oe && !gnt2_pad.o);
    endproperty
    a_host_gnt2: assert property (p_host_gnt2) else $error("host grant 2 missing");

    // Host request 2 reaches arbiter
    property p_host_req2;
        @(posedge clk) disable iff (!rst_b)
        (strapped && role == PAR_ROLE_HOST && !req_n_in[2]) |=> arb_req[1];
    endproperty
    a_host_req2: assert property (p_host_req2) else $error("request 2 lost");

    // Satellite never feeds the arbiter, edge 1 included
    property p_sat_no_arb;
        @(posedge clk) disable iff (!rst_b)
        (strapped && role != PAR_ROLE_HOST) |-> (arb_req == 2'b00);
    endproperty
    a_sat_no_arb: assert property (p_sat_no_arb) else $error("arbiter request in satellite");

    // Satellite own request drives request 0 low
    property p_sat_req0;
        @(posedge clk) disable iff (!rst_b)
        (strapped && role != PAR_ROLE_HOST && own_req) |=> (req0_pad.oe && !req0_pad.o);
    endproperty
    a_sat_req0: assert property (p_sat_req0) else $error("own request not driven");

    // Satellite grant 0 is an input
    property p_sat_gnt0;
        @(posedge clk) disable iff (!rst_b)
        (strapped && role != PAR_ROLE_HOST) |=> (!gnt0_pad.oe && (own_gnt == !$past(gnt_n_in[0])));
    endproperty
    a_sat_gnt0: assert property (p_sat_gnt0) else $error("grant 0 role wrong");
endmodule : par_pin_roles

// File: test/par_far_side.sv
// Far side of the pins: external masters, host and board pull-ups.
// Assumes pad structs from the device and levels set by the bench.
`timescale 1ns/1ps
module par_far_side
    import par_pkg::*;
(
    input par_pad_s req0_pad,
    input par_pad_s gnt2_pad,
    input par_pad_s gnt1_pad,
    input par_pad_s gnt0_pad,
    input wire logic host_req2_n,
    input wire logic ext_req0_n,
    input wire logic ext_gnt0_n,
    input wire logic lock_drv_n,
    output logic [2:0] req_n_in,
    output logic [2:0] gnt_n_in,
    output logic lock_n
);
    // Wire levels; released grant lines 2 and 1 float to their pull-ups, released lines 0 follow the external drivers
    assign req_n_in[2] = host_req2_n;
    assign req_n_in[1] = 1'b1;
    assign req_n_in[0] = req0_pad.oe ? req0_pad.o : ext_req0_n;
    assign gnt_n_in[2] = gnt2_pad.oe ? gnt2_pad.o : 1'b1;
    assign gnt_n_in[1] = gnt1_pad.oe ? gnt1_pad.o : 1'b1;
    assign gnt_n_in[0] = gnt0_pad.oe ? gnt0_pad.o : ext_gnt0_n;
    // Only the current master drives lock
    assign lock_n = lock_drv_n;
endmodule : par_far_side

// File: test/par_pin_roles_bench.sv
// Bench for the pin role selector in all three roles.
// Assumes the far side model resolves every wire.
`timescale 1ns/1ps
module par_pin_roles_bench;
    import par_pkg::*;
    logic clk, rst_b, strap_satellite, strap_pci_boot;
    logic host_req2_n, ext_req0_n, ext_gnt0_n, lock_drv_n;
    logic arb_gnt2, arb_gnt0, pio7_out, pio7_oe, own_req, inta, eprom_cs;
    logic [2:0] req_n_in, gnt_n_in;
    logic lock_n, idsel, own_gnt, pio7_in, lock;
    logic [1:0] arb_req;
    par_pad_s req0_pad, gnt2_pad, gnt1_pad, gnt0_pad;
    par_role_e role;
    int err_total, n_compared, cycles;
    par_pin_roles DUT (.clk(clk), .rst_b(rst_b), .strap_satellite(strap_satellite),
        .strap_pci_boot(strap_pci_boot), .req_n_in(req_n_in), .req0_pad(req0_pad), .gnt_n_in(gnt_n_in),
        .gnt2_pad(gnt2_pad), .gnt1_pad(gnt1_pad), .gnt0_pad(gnt0_pad), .lock_n(lock_n),
        .arb_gnt2(arb_gnt2), .arb_gnt0(arb_gnt0), .pio7_out(pio7_out), .pio7_oe(pio7_oe),
        .own_req(own_req), .inta(inta), .eprom_cs(eprom_cs), .arb_req(arb_req), .idsel(idsel),
        .own_gnt(own_gnt), .pio7_in(pio7_in), .lock(lock), .role(role));
    par_far_side far (.req0_pad(req0_pad), .gnt2_pad(gnt2_pad), .gnt1_pad(gnt1_pad), .gnt0_pad(gnt0_pad),
        .host_req2_n(host_req2_n), .ext_req0_n(ext_req0_n), .ext_gnt0_n(ext_gnt0_n),
        .lock_drv_n(lock_drv_n), .req_n_in(req_n_in), .gnt_n_in(gnt_n_in), .lock_n(lock_n));
    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Inputs move 1 ns after the edge so sampling never races
    task step;
        @(posedge clk);
        #1;
    endtask : step
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Reset with straps, pass edge 1, then flip straps to prove they are ignored
    task start(input logic sat, input logic boot);
        {host_req2_n, ext_req0_n, ext_gnt0_n, lock_drv_n} = 4'hf;
        {arb_gnt2, arb_gnt0, pio7_out, pio7_oe, own_req, inta, eprom_cs} = 7'h00;
        rst_b = 1'b0;
        strap_satellite = sat;
        strap_pci_boot = boot;
        repeat (8) step;
        rst_b = 1'b1;
        step;
        strap_satellite = ~sat;
        strap_pci_boot = ~boot;
    endtask : start
    task host_case;
        start(1'b0, 1'b0);
        chk(role, PAR_ROLE_HOST);
        chk({gnt1_pad.oe, gnt_n_in[1]}, 8'h03);
        {host_req2_n, ext_req0_n, arb_gnt2, arb_gnt0, pio7_oe, pio7_out, lock_drv_n} = 7'b0111100;
        step;
        chk(arb_req, 8'h02);
        chk(gnt_n_in[2], 8'h00);
        chk({gnt0_pad.oe, gnt_n_in[0]}, 8'h02);
        chk(gnt_n_in[1], 8'h00);
        chk({req0_pad.oe, lock}, 8'h01);
        {host_req2_n, ext_req0_n, arb_gnt2, arb_gnt0, pio7_out, lock_drv_n, own_req} = 7'b1001111;
        step;
        chk(arb_req, 8'h01);
        chk({gnt_n_in[2], gnt_n_in[0]}, 8'h02);
        chk({gnt_n_in[1], lock, req0_pad.oe}, 8'h04);
        chk(pio7_in, 8'h00);
        chk(role, PAR_ROLE_HOST);
    endtask : host_case
    task sat_case;
        start(1'b1, 1'b0);
        chk(role, PAR_ROLE_SAT);
        chk({gnt1_pad.oe, gnt_n_in[1]}, 8'h02);
        {own_req, inta, ext_gnt0_n, eprom_cs} = 4'b1101;
        step;
        chk(idsel, 8'h01);
        chk({req0_pad.oe, req_n_in[0]}, 8'h02);
        chk({gnt2_pad.oe, gnt_n_in[2]}, 8'h02);
        chk({gnt0_pad.oe, own_gnt, arb_req}, 8'h04);
        {host_req2_n, own_req, inta, ext_gnt0_n} = 4'b0001;
        step;
        chk({idsel, req_n_in[0], own_gnt}, 8'h02);
        chk({gnt2_pad.oe, gnt_n_in[2]}, 8'h01);
        chk({gnt_n_in[1], role}, {5'h00, 1'b0, PAR_ROLE_SAT});
    endtask : sat_case
    task boot_case;
        start(1'b1, 1'b1);
        chk(role, PAR_ROLE_SAT_BOOT);
        chk(gnt1_pad.oe, 8'h00);
        step;
        chk({gnt1_pad.oe, gnt_n_in[1]}, 8'h02);
        eprom_cs = 1'b1;
        step;
        chk({gnt1_pad.oe, gnt_n_in[1]}, 8'h03);
    endtask : boot_case
    task results;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    // Hang guard well above the 33 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            results();
        end
    end
    initial begin
        err_total = 0;
        n_compared = 0;
        cycles = 0;
        host_case();
        sat_case();
        boot_case();
        results();
    end
endmodule : par_pin_roles_bench
